// *** srq_pkg.sv ***
// shared constants, field positions and command codes of the status block
package srq_pkg;
  localparam int SRQ_BYTE_W = 8;
  localparam int SRQ_GRP_W = 16;
  localparam int SRQ_CMD_W = 5;
  // -----------------------------------------------------------------
  // status byte bit positions
  // -----------------------------------------------------------------
  localparam int SRQ_SB_ERRQ = 2;
  localparam int SRQ_SB_QUES = 3;
  localparam int SRQ_SB_MAV = 4;
  localparam int SRQ_SB_ESB = 5;
  localparam int SRQ_SB_MSS = 6;
  localparam int SRQ_SB_OPER = 7;
  // -----------------------------------------------------------------
  // standard event latch bit positions
  // -----------------------------------------------------------------
  localparam int SRQ_EVL_OPC = 0;
  localparam int SRQ_EVL_DDE = 3;
  localparam int SRQ_EVL_CME = 5;
  localparam logic [7:0] SRQ_EVL_USED = 8'h29;
  localparam logic [7:0] SRQ_SB_NO_MSS = 8'hBF;
  // -----------------------------------------------------------------
  // reset values and fixed replies
  // -----------------------------------------------------------------
  localparam logic [7:0] SRQ_BYTE_RST = 8'h00;
  localparam logic [15:0] SRQ_PTR_RST = 16'hFFFF;
  localparam logic [15:0] SRQ_NTR_RST = 16'h0000;
  localparam logic [15:0] SRQ_ENA_RST = 16'h0000;
  localparam logic [15:0] SRQ_EVT_RST = 16'h0000;
  localparam logic [15:0] SRQ_OPC_REPLY = 16'h0001;

  typedef enum logic [SRQ_CMD_W-1:0] {
    SRQ_CMD_NOP, SRQ_CMD_CLS, SRQ_CMD_RST, SRQ_CMD_OPC, SRQ_CMD_OPC_Q,
    SRQ_CMD_EVM_WR, SRQ_CMD_EVM_RD, SRQ_CMD_RQM_WR, SRQ_CMD_RQM_RD,
    SRQ_CMD_EVL_RD, SRQ_CMD_SB_RD,
    SRQ_CMD_OPER_COND_RD, SRQ_CMD_OPER_EVT_RD, SRQ_CMD_OPER_ENA_WR,
    SRQ_CMD_OPER_ENA_RD, SRQ_CMD_OPER_PTR_WR, SRQ_CMD_OPER_NTR_WR,
    SRQ_CMD_QUES_COND_RD, SRQ_CMD_QUES_EVT_RD, SRQ_CMD_QUES_ENA_WR,
    SRQ_CMD_QUES_ENA_RD, SRQ_CMD_QUES_PTR_WR, SRQ_CMD_QUES_NTR_WR
  } srq_cmd_t;
endpackage

// *** srq_grp_if.sv ***
// carrier between the core and one transition-filtered status group
`timescale 1ns/100ps
`default_nettype none
interface srq_grp_if;
  logic [15:0] cond;
  logic [15:0] wdata;
  logic wr_ptr;
  logic wr_ntr;
  logic wr_ena;
  logic rd_evt;
  logic clr;
  logic [15:0] event_val;
  logic [15:0] enable_val;
  logic summary;
  modport ctl (output cond, wdata, wr_ptr, wr_ntr, wr_ena, rd_evt, clr,
    input event_val, enable_val, summary);
  modport grp (input cond, wdata, wr_ptr, wr_ntr, wr_ena, rd_evt, clr,
    output event_val, enable_val, summary);
endinterface
`default_nettype wire

// *** srq_status_group.sv ***
// condition, transition masks, event latch and enable of one status group
`timescale 1ns/100ps
`default_nettype none
module srq_status_group (
  input wire logic clk_in,
  input wire logic arst_n_in,
  srq_grp_if.grp grp
);
  logic [15:0] cond_q, cond_d, ptr_q, ptr_d, ntr_q, ntr_d;
  logic [15:0] event_q, event_d, ena_q, ena_d, hit;
  logic sum_q, sum_d;

  always_comb
  begin
    hit = (grp.cond & ~cond_q & ptr_q) | (~grp.cond & cond_q & ntr_q);
    cond_d = grp.cond;
    ptr_d = grp.wr_ptr ? grp.wdata : ptr_q;
    ntr_d = grp.wr_ntr ? grp.wdata : ntr_q;
    ena_d = grp.wr_ena ? grp.wdata : ena_q;
    event_d = event_q;
    if (grp.clr || grp.rd_evt)
    begin
      event_d = srq_pkg::SRQ_EVT_RST;
    end
    // a new edge in the clearing cycle still latches
    event_d = event_d | hit;
    sum_d = |(event_d & ena_d);
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cond_q <= 16'h0000;
      ptr_q <= srq_pkg::SRQ_PTR_RST;
      ntr_q <= srq_pkg::SRQ_NTR_RST;
      ena_q <= srq_pkg::SRQ_ENA_RST;
      event_q <= srq_pkg::SRQ_EVT_RST;
      sum_q <= 1'b0;
    end
    else
    begin
      cond_q <= cond_d;
      ptr_q <= ptr_d;
      ntr_q <= ntr_d;
      ena_q <= ena_d;
      event_q <= event_d;
      sum_q <= sum_d;
    end
  end

  assign grp.event_val = event_q;
  assign grp.enable_val = ena_q;
  assign grp.summary = sum_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  grp_edge_latch_a: assert property ((hit != 16'h0000) |=>
    ((event_q & $past(hit)) == $past(hit)))
    else $error("selected edge not latched into event bits");
endmodule
`default_nettype wire

// *** srq_opc_tracker.sv ***
// operation-complete arming and held operation-complete query
`timescale 1ns/100ps
`default_nettype none
module srq_opc_tracker (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic opc_cmd_in,
  input wire logic query_cmd_in,
  input wire logic cancel_in,
  input wire logic pending_in,
  output logic set_out,
  output logic done_out
);
  logic armed_q, armed_d, qwait_q, qwait_d, set_q, set_d, done_q, done_d;

  always_comb
  begin
    armed_d = armed_q;
    set_d = 1'b0;
    if (armed_q && !pending_in)
    begin
      set_d = 1'b1;
      armed_d = 1'b0;
    end
    if (opc_cmd_in)
    begin
      armed_d = 1'b1;
    end
    if (cancel_in)
    begin
      armed_d = 1'b0;
    end
    qwait_d = qwait_q;
    done_d = 1'b0;
    // no zero answer exists: the query just waits
    if (qwait_q && !pending_in)
    begin
      done_d = 1'b1;
      qwait_d = 1'b0;
    end
    if (query_cmd_in)
    begin
      qwait_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      armed_q <= 1'b0;
      qwait_q <= 1'b0;
      set_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
      qwait_q <= qwait_d;
      set_q <= set_d;
      done_q <= done_d;
    end
  end

  assign set_out = set_q;
  assign done_out = done_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_query_held;
    qwait_q && pending_in;
  endsequence
  sequence s_query_free;
    qwait_q && !pending_in;
  endsequence

  opc_query_hold_a: assert property (s_query_held |=> !done_q)
    else $error("query answered while operations pending");
  opc_query_done_a: assert property (s_query_free |=> done_q ##1 !done_q)
    else $error("query not answered once operations finished");
  opc_flag_set_a: assert property (armed_q && !pending_in && !cancel_in && !opc_cmd_in
    |=> set_q && !armed_q)
    else $error("operation complete flag not raised");
endmodule
`default_nettype wire

// *** srq_status_core.sv ***
// status byte, event latch, masks and service request of the instrument
//
// Operation
// - summary bit with clear request-enable mask bit never raises a request
// - event bits latch until the latch is read, read returns then clears
// - operation group latches events on masked rising or falling condition edges
// - questionable group has the same structure with its own summary
// - clear-status empties groups, error queue, event latch, status byte, measurement
// - enabled event bits are ORed into status byte bit 5
// - enabled events request service only when bit 5 is request-enabled
// - event enable mask survives clear-status, reset and device clear
// - both masks are eight bits, values 0 to 255; event latch is eight bits, only bits 0, 3 and 5 used
// - latch bits: 0 complete, 3 device error, 5 command error, rest zero
// - arming command clears complete flag, flag sets when nothing pending
// - completion query answers one only after pending work ends, never zero
// - reset stops measurement, defaults configuration, empties error queue
// - request raised when an enabled status byte bit becomes true
// - byte bits: 2 errors, 3 questionable, 4 message, 5 events, 7 operation
// - bit 6 is true whenever any other status byte bit is true
// - summary bits 3, 5 and 7 are each the OR of their group's enabled bits; bits 2 and 4 come straight from inputs
`timescale 1ns/100ps
`default_nettype none
module srq_status_core (
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [4:0] CMD_CODE_IN,
  input wire logic [15:0] CMD_ARG_IN,
  output logic CMD_READY_OUT,
  output logic RSP_VALID_OUT,
  output logic [15:0] RSP_DATA_OUT,
  input wire logic EVT_DEV_ERR_IN,
  input wire logic EVT_CMD_ERR_IN,
  input wire logic PENDING_IN,
  input wire logic MAV_IN,
  input wire logic ERRQ_NONEMPTY_IN,
  input wire logic [15:0] OPER_COND_IN,
  input wire logic [15:0] QUES_COND_IN,
  output logic [7:0] SUM_BYTE_OUT,
  output logic SRQ_OUT,
  output logic MEAS_STOP_OUT,
  output logic MEAS_CLEAR_OUT,
  output logic ERRQ_CLEAR_OUT,
  output logic CONFIG_DEFAULT_OUT
);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic any_set8(input logic [7:0] val, input logic [7:0] mask);
    any_set8 = |(val & mask);
  endfunction

  srq_pkg::srq_cmd_t cmd;
  logic accept;
  logic do_cls, do_rst, do_opc, do_opcq, do_evm_wr, do_rqm_wr, do_evl_rd;
  logic rd_hit;
  logic [15:0] rd_val;
  logic opc_set, opc_done;
  logic [7:0] evl_q, evl_d, evm_q, evm_d, rqm_q, rqm_d;
  logic [7:0] sb_q, sb_d;
  logic srq_q, srq_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [15:0] rsp_data_q, rsp_data_d;
  logic meas_stop_q, meas_stop_d, meas_clr_q, meas_clr_d;
  logic errq_clr_q, errq_clr_d, cfg_def_q, cfg_def_d;
  logic [7:0] ev_set;
  logic esb;

  srq_grp_if oper_if ();
  srq_grp_if ques_if ();

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  always_comb
  begin
    cmd = srq_pkg::srq_cmd_t'(CMD_CODE_IN);
    accept = CMD_VALID_IN && ready_q;
    do_cls = 1'b0;
    do_rst = 1'b0;
    do_opc = 1'b0;
    do_opcq = 1'b0;
    do_evm_wr = 1'b0;
    do_rqm_wr = 1'b0;
    do_evl_rd = 1'b0;
    rd_hit = 1'b0;
    rd_val = 16'h0000;
    oper_if.wr_ptr = 1'b0;
    oper_if.wr_ntr = 1'b0;
    oper_if.wr_ena = 1'b0;
    oper_if.rd_evt = 1'b0;
    ques_if.wr_ptr = 1'b0;
    ques_if.wr_ntr = 1'b0;
    ques_if.wr_ena = 1'b0;
    ques_if.rd_evt = 1'b0;
    if (accept)
    begin
      unique case (cmd)
        srq_pkg::SRQ_CMD_NOP: ;
        srq_pkg::SRQ_CMD_CLS: do_cls = 1'b1;
        srq_pkg::SRQ_CMD_RST: do_rst = 1'b1;
        srq_pkg::SRQ_CMD_OPC: do_opc = 1'b1;
        srq_pkg::SRQ_CMD_OPC_Q: do_opcq = 1'b1;
        srq_pkg::SRQ_CMD_EVM_WR: do_evm_wr = 1'b1;
        srq_pkg::SRQ_CMD_RQM_WR: do_rqm_wr = 1'b1;
        srq_pkg::SRQ_CMD_EVM_RD:
        begin
          rd_hit = 1'b1;
          rd_val = {8'h00, evm_q};
        end
        srq_pkg::SRQ_CMD_RQM_RD:
        begin
          rd_hit = 1'b1;
          rd_val = {8'h00, rqm_q};
        end
        srq_pkg::SRQ_CMD_EVL_RD:
        begin
          do_evl_rd = 1'b1;
          rd_hit = 1'b1;
          rd_val = {8'h00, evl_q};
        end
        srq_pkg::SRQ_CMD_SB_RD:
        begin
          rd_hit = 1'b1;
          rd_val = {8'h00, sb_q};
        end
        srq_pkg::SRQ_CMD_OPER_COND_RD:
        begin
          rd_hit = 1'b1;
          rd_val = OPER_COND_IN;
        end
        srq_pkg::SRQ_CMD_OPER_EVT_RD:
        begin
          rd_hit = 1'b1;
          rd_val = oper_if.event_val;
          oper_if.rd_evt = 1'b1;
        end
        srq_pkg::SRQ_CMD_OPER_ENA_WR: oper_if.wr_ena = 1'b1;
        srq_pkg::SRQ_CMD_OPER_ENA_RD:
        begin
          rd_hit = 1'b1;
          rd_val = oper_if.enable_val;
        end
        srq_pkg::SRQ_CMD_OPER_PTR_WR: oper_if.wr_ptr = 1'b1;
        srq_pkg::SRQ_CMD_OPER_NTR_WR: oper_if.wr_ntr = 1'b1;
        srq_pkg::SRQ_CMD_QUES_COND_RD:
        begin
          rd_hit = 1'b1;
          rd_val = QUES_COND_IN;
        end
        srq_pkg::SRQ_CMD_QUES_EVT_RD:
        begin
          rd_hit = 1'b1;
          rd_val = ques_if.event_val;
          ques_if.rd_evt = 1'b1;
        end
        srq_pkg::SRQ_CMD_QUES_ENA_WR: ques_if.wr_ena = 1'b1;
        srq_pkg::SRQ_CMD_QUES_ENA_RD:
        begin
          rd_hit = 1'b1;
          rd_val = ques_if.enable_val;
        end
        srq_pkg::SRQ_CMD_QUES_PTR_WR: ques_if.wr_ptr = 1'b1;
        srq_pkg::SRQ_CMD_QUES_NTR_WR: ques_if.wr_ntr = 1'b1;
        // codes above the last command are dropped silently
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // status groups
  // -----------------------------------------------------------------
  assign oper_if.cond = OPER_COND_IN;
  assign oper_if.wdata = CMD_ARG_IN;
  assign oper_if.clr = do_cls;
  assign ques_if.cond = QUES_COND_IN;
  assign ques_if.wdata = CMD_ARG_IN;
  assign ques_if.clr = do_cls;

  srq_status_group u_oper (
    .clk_in(MCLK_IN),
    .arst_n_in(ARST_N_IN),
    .grp(oper_if.grp)
  );

  // same structure as the operation group, own summary bit
  srq_status_group u_ques (
    .clk_in(MCLK_IN),
    .arst_n_in(ARST_N_IN),
    .grp(ques_if.grp)
  );

  srq_opc_tracker u_opc (
    .clk_in(MCLK_IN),
    .arst_n_in(ARST_N_IN),
    .opc_cmd_in(do_opc),
    .query_cmd_in(do_opcq),
    .cancel_in(do_cls || do_rst),
    .pending_in(PENDING_IN),
    .set_out(opc_set),
    .done_out(opc_done)
  );

  // -----------------------------------------------------------------
  // event latch and masks
  // -----------------------------------------------------------------
  always_comb
  begin
    ev_set = 8'h00;
    ev_set[srq_pkg::SRQ_EVL_OPC] = opc_set;
    ev_set[srq_pkg::SRQ_EVL_DDE] = EVT_DEV_ERR_IN;
    ev_set[srq_pkg::SRQ_EVL_CME] = EVT_CMD_ERR_IN;
    evl_d = evl_q;
    if (do_evl_rd || do_cls)
    begin
      evl_d = srq_pkg::SRQ_BYTE_RST;
    end
    if (do_opc)
    begin
      evl_d[srq_pkg::SRQ_EVL_OPC] = 1'b0;
    end
    // an event in the read cycle survives the clear
    evl_d = (evl_d | ev_set) & srq_pkg::SRQ_EVL_USED;
    // neither clear-status nor reset touches the event mask
    evm_d = do_evm_wr ? CMD_ARG_IN[7:0] : evm_q;
    rqm_d = do_rqm_wr ? CMD_ARG_IN[7:0] : rqm_q;
  end

  // -----------------------------------------------------------------
  // status byte and request
  // -----------------------------------------------------------------
  always_comb
  begin
    esb = any_set8(evl_q, evm_q);
    sb_d = 8'h00;
    sb_d[srq_pkg::SRQ_SB_ERRQ] = ERRQ_NONEMPTY_IN;
    sb_d[srq_pkg::SRQ_SB_QUES] = ques_if.summary;
    sb_d[srq_pkg::SRQ_SB_MAV] = MAV_IN;
    sb_d[srq_pkg::SRQ_SB_ESB] = esb;
    sb_d[srq_pkg::SRQ_SB_OPER] = oper_if.summary;
    sb_d[srq_pkg::SRQ_SB_MSS] = any_set8(sb_d, srq_pkg::SRQ_SB_NO_MSS);
    // bit 6 in the enable mask is ignored, it is the summary itself
    srq_d = any_set8(sb_d, rqm_q & srq_pkg::SRQ_SB_NO_MSS);
  end

  // -----------------------------------------------------------------
  // answers, ready and action pulses
  // -----------------------------------------------------------------
  always_comb
  begin
    // a held completion query blocks further commands
    ready_d = ready_q;
    if (do_opcq)
    begin
      ready_d = 1'b0;
    end
    if (opc_done)
    begin
      ready_d = 1'b1;
    end
    rsp_valid_d = rd_hit || opc_done;
    rsp_data_d = rsp_data_q;
    if (opc_done)
    begin
      rsp_data_d = srq_pkg::SRQ_OPC_REPLY;
    end
    else if (rd_hit)
    begin
      rsp_data_d = rd_val;
    end
    meas_stop_d = do_rst;
    cfg_def_d = do_rst;
    meas_clr_d = do_cls;
    errq_clr_d = do_cls || do_rst;
  end

  always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      evl_q <= srq_pkg::SRQ_BYTE_RST;
      evm_q <= srq_pkg::SRQ_BYTE_RST;
      rqm_q <= srq_pkg::SRQ_BYTE_RST;
      sb_q <= srq_pkg::SRQ_BYTE_RST;
      srq_q <= 1'b0;
      ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      meas_stop_q <= 1'b0;
      meas_clr_q <= 1'b0;
      errq_clr_q <= 1'b0;
      cfg_def_q <= 1'b0;
    end
    else
    begin
      evl_q <= evl_d;
      evm_q <= evm_d;
      rqm_q <= rqm_d;
      sb_q <= sb_d;
      srq_q <= srq_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      meas_stop_q <= meas_stop_d;
      meas_clr_q <= meas_clr_d;
      errq_clr_q <= errq_clr_d;
      cfg_def_q <= cfg_def_d;
    end
  end

  assign CMD_READY_OUT = ready_q;
  assign RSP_VALID_OUT = rsp_valid_q;
  assign RSP_DATA_OUT = rsp_data_q;
  assign SUM_BYTE_OUT = sb_q;
  assign SRQ_OUT = srq_q;
  assign MEAS_STOP_OUT = meas_stop_q;
  assign MEAS_CLEAR_OUT = meas_clr_q;
  assign ERRQ_CLEAR_OUT = errq_clr_q;
  assign CONFIG_DEFAULT_OUT = cfg_def_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  sequence s_quiet_events;
    !EVT_DEV_ERR_IN && !EVT_CMD_ERR_IN && !opc_set;
  endsequence
  sequence s_cls_taken;
    accept && cmd == srq_pkg::SRQ_CMD_CLS;
  endsequence
  sequence s_cls_done;
    evl_q == 8'h00 && MEAS_CLEAR_OUT && ERRQ_CLEAR_OUT;
  endsequence

  srq_mask_gate_a: assert property (SRQ_OUT |->
    any_set8(SUM_BYTE_OUT, $past(rqm_q) & srq_pkg::SRQ_SB_NO_MSS))
    else $error("request raised with no enabled status bit");
  srq_drop_a: assert property (!SRQ_OUT |->
    !any_set8(SUM_BYTE_OUT, $past(rqm_q) & srq_pkg::SRQ_SB_NO_MSS))
    else $error("request low while an enabled status bit is set");
  evl_read_clear_a: assert property ((accept && cmd == srq_pkg::SRQ_CMD_EVL_RD)
    ##0 s_quiet_events |=> evl_q == 8'h00 && RSP_VALID_OUT)
    else $error("event latch not cleared by its read");
  evl_bit_hold_a: assert property (evl_q[srq_pkg::SRQ_EVL_DDE] && !do_cls
    && !do_evl_rd |=> evl_q[srq_pkg::SRQ_EVL_DDE])
    else $error("latched event bit lost without a clear");
  evl_fields_a: assert property ((evl_q & ~srq_pkg::SRQ_EVL_USED) == 8'h00)
    else $error("unused event latch bit set");
  evm_keep_a: assert property (accept && (cmd == srq_pkg::SRQ_CMD_CLS ||
    cmd == srq_pkg::SRQ_CMD_RST) |=> $stable(evm_q))
    else $error("event enable mask changed by clear or reset");
  esb_summary_a: assert property (SUM_BYTE_OUT[srq_pkg::SRQ_SB_ESB] ==
    $past(any_set8(evl_q, evm_q)))
    else $error("event summary bit does not match enabled events");
  mss_summary_a: assert property (SUM_BYTE_OUT[srq_pkg::SRQ_SB_MSS] ==
    any_set8(SUM_BYTE_OUT, srq_pkg::SRQ_SB_NO_MSS))
    else $error("master summary bit wrong");
  cls_clear_a: assert property (s_cls_taken ##0 s_quiet_events |=> s_cls_done)
    else $error("clear-status did not clear");
  rst_actions_a: assert property (accept && cmd == srq_pkg::SRQ_CMD_RST |=>
    MEAS_STOP_OUT && CONFIG_DEFAULT_OUT && ERRQ_CLEAR_OUT ##1 !MEAS_STOP_OUT)
    else $error("reset actions not pulsed");
endmodule
`default_nettype wire

// *** srq_host_model.sv ***
// host controller model driving the status command port
`timescale 1ns/100ps
`default_nettype none
module srq_host_model (
  input wire logic clk_in,
  input wire logic ready_in,
  input wire logic rsp_valid_in,
  input wire logic [15:0] rsp_data_in,
  output logic valid_out,
  output logic [4:0] code_out,
  output logic [15:0] arg_out
);
  initial
  begin
    valid_out = 1'b0;
    code_out = 5'h00;
    arg_out = 16'h0000;
  end
  // one word per command; ready only drops while this task waits on a query
  task automatic cmd(input logic [4:0] code, input logic [15:0] arg, input bit rd,
    output logic [15:0] data);
    int n;
    data = 16'hXXXX;
    @(posedge clk_in);
    valid_out <= 1'b1;
    code_out <= code;
    arg_out <= arg;
    @(posedge clk_in);
    // a held completion query keeps ready low: stay on the lines until taken
    while (ready_in !== 1'b1)
    begin
      @(posedge clk_in);
    end
    valid_out <= 1'b0;
    // released lines must not keep looking valid
    code_out <= ~code;
    arg_out <= ~arg;
    if (rd)
    begin
      for (n = 0; n < 200; n++)
      begin
        #1;
        if (rsp_valid_in === 1'b1)
        begin
          data = rsp_data_in;
          break;
        end
        @(posedge clk_in);
      end
    end
  endtask
endmodule
`default_nettype wire

// *** srq_status_core_test.sv ***
// self-checking bench of the status byte and service request block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module srq_status_core_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld, rdy, rvld, srq, mstop, mclr, eclr, cdef;
  logic evt_dev = 1'b0, evt_cmd = 1'b0, pend = 1'b0, mav = 1'b0, errq = 1'b0;
  logic [4:0] code;
  logic [15:0] arg, rdata, oc = 16'h0000, qc = 16'h0000, d;
  logic [7:0] sbyte;
  int failures = 0, checked = 0, cyc = 0, rsp_cnt = 0, snap, g;
  bit seen_stop = 0, seen_clr = 0, seen_cfg = 0;
  logic [4:0] b;
  always #2 clk = ~clk;
  srq_host_model i_host (.clk_in(clk), .rsp_valid_in(rvld), .rsp_data_in(rdata),
    .ready_in(rdy), .valid_out(vld), .code_out(code), .arg_out(arg));
  srq_status_core i_dut (.MCLK_IN(clk), .ARST_N_IN(rst_n), .CMD_VALID_IN(vld),
    .CMD_CODE_IN(code), .CMD_ARG_IN(arg), .CMD_READY_OUT(rdy), .RSP_VALID_OUT(rvld),
    .RSP_DATA_OUT(rdata), .EVT_DEV_ERR_IN(evt_dev), .EVT_CMD_ERR_IN(evt_cmd),
    .PENDING_IN(pend), .MAV_IN(mav), .ERRQ_NONEMPTY_IN(errq), .OPER_COND_IN(oc),
    .QUES_COND_IN(qc), .SUM_BYTE_OUT(sbyte), .SRQ_OUT(srq), .MEAS_STOP_OUT(mstop),
    .MEAS_CLEAR_OUT(mclr), .ERRQ_CLEAR_OUT(eclr), .CONFIG_DEFAULT_OUT(cdef));
  // pulses are caught sticky so their exact cycle does not matter here
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rvld === 1'b1) rsp_cnt <= rsp_cnt + 1;
    if (mstop === 1'b1) seen_stop <= 1;
    if (mclr === 1'b1 && eclr === 1'b1) seen_clr <= 1;
    if (cdef === 1'b1) seen_cfg <= 1;
    if (cyc == 6000)
    begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [4:0] c, logic [15:0] a);
    i_host.cmd(c, a, 0, d);
  endtask
  task automatic rd(logic [4:0] c, logic [15:0] e, string nm);
    i_host.cmd(c, 16'h0000, 1, d);
    `CHK(nm, e, d)
  endtask
  task automatic pulse(logic dv, logic cm);
    @(posedge clk);
    evt_dev <= dv;
    evt_cmd <= cm;
    @(posedge clk);
    evt_dev <= 1'b0;
    evt_cmd <= 1'b0;
    tick(3);
  endtask
  task automatic setc(logic [15:0] v);
    @(posedge clk);
    if (g == 0) oc <= v;
    else qc <= v;
    tick(4);
  endtask
  initial
  begin
    tick(4);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK("sbyte", 8'h00, sbyte)
    rd(srq_pkg::SRQ_CMD_EVM_RD, 16'h0000, "evmask");
    wr(srq_pkg::SRQ_CMD_EVM_WR, 16'h00A5);
    rd(srq_pkg::SRQ_CMD_EVM_RD, 16'h00A5, "evmask");
    wr(srq_pkg::SRQ_CMD_EVM_WR, 16'h0020);
    wr(srq_pkg::SRQ_CMD_RQM_WR, 16'h0040);
    pulse(0, 1);
    `CHK("srq", 1'b0, srq)
    rd(srq_pkg::SRQ_CMD_EVL_RD, 16'h0020, "evlat");
    wr(srq_pkg::SRQ_CMD_RQM_WR, 16'h0020);
    rd(srq_pkg::SRQ_CMD_RQM_RD, 16'h0020, "rqmask");
    pulse(0, 1);
    `CHK("sbyte", 8'h60, sbyte)
    `CHK("srq", 1'b1, srq)
    rd(srq_pkg::SRQ_CMD_SB_RD, 16'h0060, "sbyte");
    `CHK("sbyte", 8'h60, sbyte)
    rd(srq_pkg::SRQ_CMD_EVL_RD, 16'h0020, "evlat");
    rd(srq_pkg::SRQ_CMD_EVL_RD, 16'h0000, "evlat");
    tick(3);
    `CHK("srq", 1'b0, srq)
    pulse(1, 1);
    rd(srq_pkg::SRQ_CMD_EVL_RD, 16'h0028, "evlat");
    wr(srq_pkg::SRQ_CMD_RQM_WR, 16'h0010);
    @(posedge clk);
    mav <= 1'b1;
    errq <= 1'b1;
    tick(3);
    `CHK("sbyte", 8'h54, sbyte)
    `CHK("srq", 1'b1, srq)
    @(posedge clk);
    mav <= 1'b0;
    errq <= 1'b0;
    tick(3);
    `CHK("srq", 1'b0, srq)
    for (g = 0; g < 2; g++)
    begin
      b = 5'(srq_pkg::SRQ_CMD_OPER_COND_RD) + 5'(g * 6);
      wr(b + 5'h02, 16'h0001);
      rd(b + 5'h03, 16'h0001, "ena");
      setc(16'h0003);
      `CHK("sbyte", (g == 0) ? 8'hC0 : 8'h48, sbyte)
      rd(b, 16'h0003, "cond");
      rd(b + 5'h01, 16'h0003, "evt");
      rd(b + 5'h01, 16'h0000, "evt");
      wr(b + 5'h04, 16'h0000);
      wr(b + 5'h05, 16'h0001);
      setc(16'h0000);
      rd(b + 5'h01, 16'h0001, "evt");
      setc(16'h0001);
      rd(b + 5'h01, 16'h0000, "evt");
      `CHK("sbyte", 8'h00, sbyte)
    end
    g = 0;
    pulse(0, 1);
    setc(16'h0000);
    wr(srq_pkg::SRQ_CMD_CLS, 16'h0000);
    tick(3);
    `CHK("sbyte", 8'h00, sbyte)
    `CHK("clr", 1'b1, seen_clr)
    rd(srq_pkg::SRQ_CMD_EVL_RD, 16'h0000, "evlat");
    rd(srq_pkg::SRQ_CMD_OPER_EVT_RD, 16'h0000, "evt");
    wr(srq_pkg::SRQ_CMD_RST, 16'h0000);
    tick(3);
    rd(srq_pkg::SRQ_CMD_EVM_RD, 16'h0020, "evmask");
    `CHK("stop", 2'b11, {seen_stop, seen_cfg})
    wr(srq_pkg::SRQ_CMD_EVM_WR, 16'h0000);
    rd(srq_pkg::SRQ_CMD_EVM_RD, 16'h0000, "evmask");
    @(posedge clk);
    pend <= 1'b1;
    wr(srq_pkg::SRQ_CMD_OPC, 16'h0000);
    tick(5);
    rd(srq_pkg::SRQ_CMD_EVL_RD, 16'h0000, "evlat");
    @(posedge clk);
    pend <= 1'b0;
    tick(5);
    rd(srq_pkg::SRQ_CMD_EVL_RD, 16'h0001, "evlat");
    @(posedge clk);
    pend <= 1'b1;
    // let the count of the last answer settle first
    #1;
    snap = rsp_cnt;
    fork
      rd(srq_pkg::SRQ_CMD_OPC_Q, 16'h0001, "opcq");
      begin
        tick(10);
        `CHK("held", snap, rsp_cnt)
        `CHK("rdy", 1'b0, rdy)
        @(posedge clk);
        pend <= 1'b0;
      end
    join
    test_done();
  end
endmodule
`default_nettype wire
